// ===== prwr_regs.sv
// register bank and window decode for the second x4 root controller
`timescale 1ns/1ps
// What this block does
// - start bit 0 makes window valid
// - bit 29 set: any security state allowed
// - bit 29 clear: only secure transactions accepted
// - start bits 28:1 are address 47:20
// - end bits 27:0 are address 47:20
// - fine bits 9:5 are start address 19:15
// - fine bits 4:0 are end address 19:15
// - unused upper bits read zero, ignore writes
// - all registers 32 bits, reset to zero
// - high mmio window end at 0x114
// - translated window registers at 0x118, 0x11c
// - config window registers at 0x120, 0x124
// - second ecam registers at 0x128, 0x12c, 0x130
// - x8 first ecam start at 0x200
module prwr_regs (
	input  wire logic        ref_clk,      // 50 MHz clock
	input  wire logic        rst,          // synchronous reset, active high
	input  wire logic [11:0] reg_addr,     // register byte address
	input  wire logic [31:0] reg_wdata,    // write data
	input  wire logic        reg_wr,       // write strobe
	input  wire logic        reg_rd,       // read strobe
	output logic      [31:0] reg_rdata,    // read data, cycle after strobe
	input  wire logic [47:0] txn_addr,     // transaction address to decode
	input  wire logic        txn_secure,   // transaction is secure
	output logic      [2:0]  win_hit,      // valid window address match
	output logic      [2:0]  win_allow,    // match and security permits
	output logic      [27:0] hmmio_end,    // high mmio window end bits 47:20
	output logic      [29:0] x8_ec1_start  // x8 first ecam start fields
);
	// register storage
	logic [31:0] hmmio_end_ff, tr_start_ff, tr_end_ff, cfg_start_ff, cfg_end_ff;
	logic [31:0] ec2_start_ff, ec2_end_ff, ec2_fine_ff, x8_start_ff;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;

	// address decode
	wire sel_hend = (reg_addr == prwr_pkg::OFS_HMMIO_END);
	wire sel_trs  = (reg_addr == prwr_pkg::OFS_TR_START);
	wire sel_tre  = (reg_addr == prwr_pkg::OFS_TR_END);
	wire sel_cfs  = (reg_addr == prwr_pkg::OFS_CFG_START);
	wire sel_cfe  = (reg_addr == prwr_pkg::OFS_CFG_END);
	wire sel_e2s  = (reg_addr == prwr_pkg::OFS_EC2_START);
	wire sel_e2e  = (reg_addr == prwr_pkg::OFS_EC2_END);
	wire sel_e2f  = (reg_addr == prwr_pkg::OFS_EC2_FINE);
	wire sel_x8s  = (reg_addr == prwr_pkg::OFS_X8_EC1_START);

	// masked write data per register kind; reserved bits never stored
	wire [31:0] wd_start = reg_wdata & prwr_pkg::START_MASK;
	wire [31:0] wd_end   = reg_wdata & prwr_pkg::END_MASK;
	wire [31:0] wd_fine  = reg_wdata & prwr_pkg::FINE_MASK;

	// register writes, all zero after reset
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			hmmio_end_ff <= prwr_pkg::RESET_VAL;
			tr_start_ff  <= prwr_pkg::RESET_VAL;
			tr_end_ff    <= prwr_pkg::RESET_VAL;
			cfg_start_ff <= prwr_pkg::RESET_VAL;
			cfg_end_ff   <= prwr_pkg::RESET_VAL;
			ec2_start_ff <= prwr_pkg::RESET_VAL;
			ec2_end_ff   <= prwr_pkg::RESET_VAL;
			ec2_fine_ff  <= prwr_pkg::RESET_VAL;
			x8_start_ff  <= prwr_pkg::RESET_VAL;
		end else if (reg_wr) begin
			if (sel_hend) hmmio_end_ff <= wd_end;
			if (sel_trs)  tr_start_ff  <= wd_start;
			if (sel_tre)  tr_end_ff    <= wd_end;
			if (sel_cfs)  cfg_start_ff <= wd_start;
			if (sel_cfe)  cfg_end_ff   <= wd_end;
			if (sel_e2s)  ec2_start_ff <= wd_start;
			if (sel_e2e)  ec2_end_ff   <= wd_end;
			if (sel_e2f)  ec2_fine_ff  <= wd_fine;
			if (sel_x8s)  x8_start_ff  <= wd_start;
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (reg_rd) begin
			unique case (1'b1)
				sel_hend: nxt_rdata = hmmio_end_ff;
				sel_trs:  nxt_rdata = tr_start_ff;
				sel_tre:  nxt_rdata = tr_end_ff;
				sel_cfs:  nxt_rdata = cfg_start_ff;
				sel_cfe:  nxt_rdata = cfg_end_ff;
				sel_e2s:  nxt_rdata = ec2_start_ff;
				sel_e2e:  nxt_rdata = ec2_end_ff;
				sel_e2f:  nxt_rdata = ec2_fine_ff;
				sel_x8s:  nxt_rdata = x8_start_ff;
				default:  nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	// read data only stands in the cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (rst) rdata_ff <= prwr_pkg::RESET_VAL;
		else     rdata_ff <= nxt_rdata;
	end
	assign reg_rdata = rdata_ff;

	// windows this block decodes; high mmio and x8 fields go to neighbours
	assign hmmio_end    = hmmio_end_ff[prwr_pkg::END_ADDR_MSB:0];
	assign x8_ec1_start = x8_start_ff[prwr_pkg::START_NSEC_BIT:0];

	// per-window bounds at 1 MB granularity, second_config_space_window refined to 32 KB
	logic [31:0] st_reg [prwr_pkg::NUM_WIN];
	logic [31:0] en_reg [prwr_pkg::NUM_WIN];
	assign st_reg[prwr_pkg::WIN_TR]  = tr_start_ff;
	assign st_reg[prwr_pkg::WIN_CFG] = cfg_start_ff;
	assign st_reg[prwr_pkg::WIN_EC2] = ec2_start_ff;
	assign en_reg[prwr_pkg::WIN_TR]  = tr_end_ff;
	assign en_reg[prwr_pkg::WIN_CFG] = cfg_end_ff;
	assign en_reg[prwr_pkg::WIN_EC2] = ec2_end_ff;

	// compared over address bits 47:15; coarse windows fill low bits
	wire [4:0] fine_st = ec2_fine_ff[prwr_pkg::FINE_START_MSB:prwr_pkg::FINE_START_LSB];
	wire [4:0] fine_en = ec2_fine_ff[prwr_pkg::FINE_END_MSB:0];
	wire [32:0] txn_key = txn_addr[prwr_pkg::SYS_ADDR_W-1:prwr_pkg::FINE_LSB];

	genvar gi;
	generate
		for (gi = 0; gi < prwr_pkg::NUM_WIN; gi++) begin : g_win
			wire [27:0] st_hi = st_reg[gi][prwr_pkg::START_ADDR_MSB:prwr_pkg::START_ADDR_LSB];
			wire [27:0] en_hi = en_reg[gi][prwr_pkg::END_ADDR_MSB:0];
			wire [4:0]  st_lo = (gi == prwr_pkg::WIN_EC2) ? fine_st : 5'h00;
			wire [4:0]  en_lo = (gi == prwr_pkg::WIN_EC2) ? fine_en : 5'h1f;
			wire        valid = st_reg[gi][prwr_pkg::START_VALID_BIT];
			wire        nsec  = st_reg[gi][prwr_pkg::START_NSEC_BIT];
			wire        in_rng = (txn_key >= {st_hi, st_lo}) && (txn_key <= {en_hi, en_lo});
			assign win_hit[gi]   = valid && in_rng;
			// secure window admits only secure traffic
			assign win_allow[gi] = valid && in_rng && (nsec || txn_secure);
		end
	endgenerate

	// checks
	rd_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
		reg_rd && !(sel_hend||sel_trs||sel_tre||sel_cfs||sel_cfe||sel_e2s||sel_e2e||sel_e2f||sel_x8s)
		|=> reg_rdata == 32'h0000_0000) else $error("unmapped read not zero");
	rd_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
		!reg_rd |=> reg_rdata == 32'h0000_0000) else $error("read data without strobe");
	start_rsv_a: assert property (@(posedge ref_clk) disable iff (rst)
		reg_wr && sel_cfs ##1 reg_rd && sel_cfs |=> reg_rdata[31:30] == 2'b00)
		else $error("start reserved bits not zero");
	start_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
		reg_wr && sel_trs |=> tr_start_ff == $past(reg_wdata & prwr_pkg::START_MASK))
		else $error("start write lost");
	fine_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
		reg_wr && sel_e2f |=> ec2_fine_ff[31:10] == 22'h0 && ec2_fine_ff[9:0] == $past(reg_wdata[9:0]))
		else $error("fine bounds write wrong");
	reset_zero_a: assert property (@(posedge ref_clk)
		rst |=> (tr_start_ff == 32'h0 && cfg_start_ff == 32'h0 && ec2_start_ff == 32'h0 && win_hit == 3'b000))
		else $error("reset value not zero");
	valid_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
		!cfg_start_ff[0] |-> !win_hit[1]) else $error("invalid window matched");
	sec_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
		win_hit[0] && !tr_start_ff[29] && !txn_secure |-> !win_allow[0])
		else $error("secure window admitted non-secure");
	nsec_pass_a: assert property (@(posedge ref_clk) disable iff (rst)
		win_hit[1] && cfg_start_ff[29] |-> win_allow[1]) else $error("non-secure window refused");
	ec2_lo_a: assert property (@(posedge ref_clk) disable iff (rst)
		win_hit[2] |-> txn_addr[47:15] >= {ec2_start_ff[28:1], ec2_fine_ff[9:5]})
		else $error("second_config_space_window hit below start");
	x8_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
		reg_wr && sel_x8s |=> x8_ec1_start == $past(reg_wdata[29:0])) else $error("x8 start write lost");
	hend_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
		reg_wr && sel_hend |=> hmmio_end == $past(reg_wdata[27:0])) else $error("end write lost");

	// scenarios
	cov_hit_c: cover property (@(posedge ref_clk) disable iff (rst) win_hit[2] && win_allow[2]);
	cov_block_c: cover property (@(posedge ref_clk) disable iff (rst) win_hit[0] && !win_allow[0]);
	cov_rd_c: cover property (@(posedge ref_clk) disable iff (rst) reg_wr && sel_e2f ##1 reg_rd && sel_e2f);
endmodule

// ===== prwr_pkg.sv
// constants for the second x4 root controller address window register bank
package prwr_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned SYS_ADDR_W = 48;
	// register byte offsets
	localparam logic [11:0] OFS_HMMIO_END = 12'h114;
	localparam logic [11:0] OFS_TR_START = 12'h118;
	localparam logic [11:0] OFS_TR_END = 12'h11c;
	localparam logic [11:0] OFS_CFG_START = 12'h120;
	localparam logic [11:0] OFS_CFG_END = 12'h124;
	localparam logic [11:0] OFS_EC2_START = 12'h128;
	localparam logic [11:0] OFS_EC2_END = 12'h12c;
	localparam logic [11:0] OFS_EC2_FINE = 12'h130;
	localparam logic [11:0] OFS_X8_EC1_START = 12'h200;
	// start register fields
	localparam int unsigned START_VALID_BIT = 0;
	localparam int unsigned START_NSEC_BIT = 29;
	localparam int unsigned START_ADDR_LSB = 1;
	localparam int unsigned START_ADDR_MSB = 28;
	localparam logic [31:0] START_MASK = 32'h3fff_ffff;
	// end register fields
	localparam int unsigned END_ADDR_MSB = 27;
	localparam logic [31:0] END_MASK = 32'h0fff_ffff;
	// fine bounds register fields
	localparam int unsigned FINE_START_LSB = 5;
	localparam int unsigned FINE_START_MSB = 9;
	localparam int unsigned FINE_END_MSB = 4;
	localparam logic [31:0] FINE_MASK = 32'h0000_03ff;
	localparam logic [31:0] RESET_VAL = 32'h0000_0000;
	// address granularity boundaries
	localparam int unsigned COARSE_LSB = 20;
	localparam int unsigned FINE_LSB = 15;
	localparam int unsigned NUM_WIN = 3;
	localparam int unsigned WIN_TR = 0;
	localparam int unsigned WIN_CFG = 1;
	localparam int unsigned WIN_EC2 = 2;
endpackage

// ===== prwr_regs_bench.sv
// self-checking bench for the address window register bank
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fails++; \
	$display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module prwr_regs_bench;
	logic        ref_clk;
	logic        rst;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic [47:0] txn_addr;
	logic        txn_secure;
	logic [2:0]  win_hit;
	logic [2:0]  win_allow;
	logic [27:0] hmmio_end;
	logic [29:0] x8_ec1_start;
	int          fails;
	int          tests_run;
	// offsets and writable masks, walked as a table
	logic [11:0] ofs [9] = '{prwr_pkg::OFS_HMMIO_END, prwr_pkg::OFS_TR_START,
		prwr_pkg::OFS_TR_END, prwr_pkg::OFS_CFG_START, prwr_pkg::OFS_CFG_END,
		prwr_pkg::OFS_EC2_START, prwr_pkg::OFS_EC2_END, prwr_pkg::OFS_EC2_FINE,
		prwr_pkg::OFS_X8_EC1_START};
	logic [31:0] msk [9] = '{32'h0fff_ffff, 32'h3fff_ffff, 32'h0fff_ffff, 32'h3fff_ffff,
		32'h0fff_ffff, 32'h3fff_ffff, 32'h0fff_ffff, 32'h0000_03ff, 32'h3fff_ffff};

	prwr_regs dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txn_addr(txn_addr),
		.txn_secure(txn_secure), .win_hit(win_hit), .win_allow(win_allow),
		.hmmio_end(hmmio_end), .x8_ec1_start(x8_ec1_start));

	// 50 MHz clock
	always #10 ref_clk = ~ref_clk;

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so sample there
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, exp)
	endtask

	// decode outputs are combinational, checked once the inputs settle
	task automatic dec(input logic [47:0] a, input logic s, input logic [2:0] h,
		input logic [2:0] p);
		@(posedge ref_clk);
		txn_addr <= a;
		txn_secure <= s;
		#1;
		`CHK(win_hit, h)
		`CHK(win_allow, p)
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// whole run is about 120 cycles; this catches a hang
	initial begin
		repeat (5000) @(posedge ref_clk);
		fails++;
		report_and_stop();
	end

	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		reg_addr = 12'h000;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		txn_addr = 48'h0;
		txn_secure = 1'b0;
		fails = 0;
		tests_run = 0;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		for (int i = 0; i < 9; i++) rd(ofs[i], 32'h0000_0000);
		dec(48'h0, 1'b1, 3'h0, 3'h0);
		$display("test reset values done");
		for (int i = 0; i < 9; i++) wr(ofs[i], 32'hffff_ffff);
		for (int i = 0; i < 9; i++) rd(ofs[i], msk[i]);
		`CHK(hmmio_end, 28'hfff_ffff)
		`CHK(x8_ec1_start, 30'h3fff_ffff)
		wr(12'h134, 32'hffff_ffff);
		rd(12'h134, 32'h0000_0000);
		for (int i = 0; i < 9; i++) wr(ofs[i], 32'h0000_0000);
		$display("test masks and map done");
		// bounds first, valid last, as software must
		wr(prwr_pkg::OFS_CFG_START, 32'h0000_0020);
		wr(prwr_pkg::OFS_CFG_END, 32'h0000_0012);
		dec(48'h0000_0100_0000, 1'b1, 3'h0, 3'h0);
		wr(prwr_pkg::OFS_CFG_START, 32'h0000_0021);
		dec(48'h0000_00ff_ffff, 1'b1, 3'h0, 3'h0);
		dec(48'h0000_0100_0000, 1'b0, 3'h2, 3'h0);
		dec(48'h0000_012f_ffff, 1'b1, 3'h2, 3'h2);
		dec(48'h0000_0130_0000, 1'b1, 3'h0, 3'h0);
		wr(prwr_pkg::OFS_CFG_START, 32'h2000_0021);
		dec(48'h0000_0110_0000, 1'b0, 3'h2, 3'h2);
		wr(prwr_pkg::OFS_CFG_START, 32'h2000_0020);
		dec(48'h0000_0110_0000, 1'b1, 3'h0, 3'h0);
		$display("test config window done");
		wr(prwr_pkg::OFS_TR_END, 32'h0000_0030);
		wr(prwr_pkg::OFS_TR_START, 32'h0000_0061);
		dec(48'h0000_0300_0000, 1'b1, 3'h1, 3'h1);
		wr(prwr_pkg::OFS_EC2_END, 32'h0000_0020);
		wr(prwr_pkg::OFS_EC2_FINE, 32'h0000_0065);
		wr(prwr_pkg::OFS_EC2_START, 32'h2000_0041);
		dec(48'h0000_0201_7fff, 1'b0, 3'h0, 3'h0);
		dec(48'h0000_0201_8000, 1'b0, 3'h4, 3'h4);
		dec(48'h0000_0202_ffff, 1'b0, 3'h4, 3'h4);
		dec(48'h0000_0203_0000, 1'b0, 3'h0, 3'h0);
		$display("test translated and fine windows done");
		report_and_stop();
	end
endmodule
